// File: hw/lbps_sequencer.sv
`timescale 1ns/1ps
module lbps_sequencer #(
  parameter int RESET_HOLD_CYCLES  = lbps_pkg::RESET_HOLD_CYC,
  parameter int BOOST_START_CYCLES = lbps_pkg::BOOST_START_CYC,
  parameter int GATE_REL_CYCLES    = lbps_pkg::GATE_REL_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Supply comparators
  input  wire logic input_supply_ok,    // Above lockout threshold
  input  wire logic input_supply_det,   // Above detect threshold
  // Power good indications
  input  wire logic io_rail_one_good,
  input  wire logic io_rail_two_good,
  input  wire logic core_rail_good,
  input  wire logic source_driver_rail_good,
  input  wire logic gate_high_rail_good,
  // Host side
  input  wire logic enable,
  input  wire logic gate_in_panel_mode,
  // Rail enables
  output logic      io_rail_one_en,
  output logic      io_rail_two_en,
  output logic      core_rail_en,
  output logic      boost_one_en,
  output logic      boost_two_en,
  // Sequenced pins
  output logic      system_reset_n,
  output logic      shaped_gate_out,
  output logic      shaped_gate_oe_n,   // Low while driven
  output logic      panel_discharge_n
);
  import lbps_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  lbps_state_type  state_reg;            // Sequencer state
  lbps_state_type  state_next;           // Its next value
  logic [CNT_W-1:0] hold_cnt_reg;        // Reset hold counter
  logic [CNT_W-1:0] boost_cnt_reg;       // Boost start counter
  logic [CNT_W-1:0] gate_cnt_reg;        // Gate release counter
  logic             en_seen_reg;         // Enable has been high
  logic             en_dropped_reg;      // Enable fell after rise
  logic             boost_one_reg;       // Boost one running
  logic             boost_two_reg;       // Boost two running
  logic             gate_rel_reg;        // Release delay done
  logic             sys_rst_n_reg;       // Reset output
  logic             io_en_reg;           // Io rails enabled
  logic             core_en_reg;         // Core buck enabled
  logic             discharge_reg;       // Discharge output
  logic             run_ok;              // Sequencing allowed

  localparam logic [CNT_W-1:0] HOLD_LAST  = CNT_W'(RESET_HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] BOOST_LAST = CNT_W'(BOOST_START_CYCLES - 1);
  localparam logic [CNT_W-1:0] GATE_LAST  = CNT_W'(GATE_REL_CYCLES - 1);

  // Lockout acts as a reset on every register below
  assign run_ok = input_supply_ok && !rst;

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  // Next state of the rail ordering
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LBPS_IO_RAMP: begin
        // Both io rails must be up, not just one
        if (io_rail_one_good && io_rail_two_good) begin
          state_next = LBPS_CORE_RAMP;
        end
      end
      LBPS_CORE_RAMP: begin
        if (core_rail_good) begin
          state_next = LBPS_RST_HOLD;
        end
      end
      LBPS_RST_HOLD: begin
        if (hold_cnt_reg == HOLD_LAST) begin
          state_next = LBPS_RUN;
        end
      end
      LBPS_RUN: begin
        state_next = LBPS_RUN;
      end
      default: begin
        state_next = LBPS_IO_RAMP;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!run_ok) begin
      state_reg <= LBPS_IO_RAMP;
    end else begin
      state_reg <= state_next;
    end
  end

  // Io enables on run_ok; core enable and reset follow state
  always_ff @(posedge core_clk) begin
    if (!run_ok) begin
      io_en_reg     <= 1'b0;
      core_en_reg   <= 1'b0;
      sys_rst_n_reg <= 1'b0;
    end else begin
      io_en_reg     <= 1'b1;
      core_en_reg   <= (state_next != LBPS_IO_RAMP);
      sys_rst_n_reg <= (state_next == LBPS_RUN);
    end
  end

  // Reset hold counter; a core rail dip mid-hold does not restart it,
  // so a glitchy core supply can still see reset released on time
  always_ff @(posedge core_clk) begin
    if (!run_ok || state_reg != LBPS_RST_HOLD) begin
      hold_cnt_reg <= '0;
    end else if (hold_cnt_reg != HOLD_LAST) begin
      hold_cnt_reg <= hold_cnt_reg + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Boost converters one and two
  // ------------------------------------------------------------------
  // Enable history: a fall after a rise locks boost one off
  always_ff @(posedge core_clk) begin
    if (!run_ok) begin
      en_seen_reg    <= 1'b0;
      en_dropped_reg <= 1'b0;
    end else begin
      if (enable) begin
        en_seen_reg <= 1'b1;
      end
      if (en_seen_reg && !enable) begin
        en_dropped_reg <= 1'b1;
      end
    end
  end

  // Delay starts once both enable and reset release hold
  always_ff @(posedge core_clk) begin
    if (!run_ok || !sys_rst_n_reg || !enable || en_dropped_reg) begin
      boost_cnt_reg <= '0;
      boost_one_reg <= 1'b0;
    end else if (boost_cnt_reg == BOOST_LAST) begin
      boost_one_reg <= 1'b1;
    end else begin
      boost_cnt_reg <= boost_cnt_reg + 1'b1;
    end
  end

  // Boost two starts once boost one runs and the source driver rail is good, then holds
  always_ff @(posedge core_clk) begin
    if (!run_ok) begin
      boost_two_reg <= 1'b0;
    end else if (boost_one_reg && source_driver_rail_good) begin
      boost_two_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Gate shaping and discharge
  // ------------------------------------------------------------------
  // Release delay after gate high rail is good
  always_ff @(posedge core_clk) begin
    if (!run_ok || !boost_two_reg || !gate_high_rail_good) begin
      gate_cnt_reg <= '0;
      gate_rel_reg <= 1'b0;
    end else if (gate_cnt_reg == GATE_LAST) begin
      gate_rel_reg <= 1'b1;
    end else begin
      gate_cnt_reg <= gate_cnt_reg + 1'b1;
    end
  end

  // Discharge output per panel mode
  always_ff @(posedge core_clk) begin
    if (!run_ok) begin
      discharge_reg <= 1'b0;
    end else if (gate_in_panel_mode) begin
      discharge_reg <= gate_rel_reg;
    end else begin
      discharge_reg <= input_supply_det;
    end
  end

  // Outputs
  assign io_rail_one_en    = io_en_reg;
  assign io_rail_two_en    = io_en_reg;
  assign core_rail_en      = core_en_reg;
  assign boost_one_en      = boost_one_reg;
  assign boost_two_en      = boost_two_reg;
  assign system_reset_n    = sys_rst_n_reg;
  assign panel_discharge_n = discharge_reg;
  // Outside panel mode the gate output floats until release
  assign shaped_gate_out   = gate_rel_reg;
  assign shaped_gate_oe_n  = !(gate_rel_reg || gate_in_panel_mode);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  chk_lockout_off: assert property (@(posedge core_clk)
    !input_supply_ok |=> !io_rail_one_en && !core_rail_en && !boost_one_en)
    else $error("outputs live during lockout");
  chk_io_start: assert property (@(posedge core_clk) disable iff (rst)
    input_supply_ok |=> io_rail_one_en && io_rail_two_en)
    else $error("io rails not started");
  chk_core_order: assert property (@(posedge core_clk)
    $rose(core_rail_en) |-> $past(io_rail_one_good) && $past(io_rail_two_good))
    else $error("core started before io rails");
  chk_reset_hold: assert property (@(posedge core_clk) disable iff (rst)
    $rose(system_reset_n) |-> $past(hold_cnt_reg) == HOLD_LAST)
    else $error("reset released early");
  chk_boost_order: assert property (@(posedge core_clk)
    boost_one_en |-> system_reset_n && $past(enable))
    else $error("boost one without enable and reset");
  chk_boost_latch: assert property (@(posedge core_clk) disable iff (rst)
    en_dropped_reg && input_supply_ok |=> !boost_one_en)
    else $error("boost one restarted after enable drop");
  chk_boost_two: assert property (@(posedge core_clk)
    $rose(boost_two_en) |-> $past(source_driver_rail_good))
    else $error("boost two early");
  chk_panel_discharge: assert property (@(posedge core_clk) disable iff (rst)
    gate_in_panel_mode && !gate_rel_reg |=> !panel_discharge_n)
    else $error("discharge released early");
  chk_gate_float: assert property (@(posedge core_clk)
    !gate_in_panel_mode && !gate_rel_reg |-> shaped_gate_oe_n)
    else $error("gate output driven early");
  cov_reset_out: cover property (@(posedge core_clk) $rose(system_reset_n));
  cov_boost_one: cover property (@(posedge core_clk) $rose(boost_one_en));
  cov_gate_rel: cover property (@(posedge core_clk) $rose(gate_rel_reg));
  cov_drop: cover property (@(posedge core_clk) $rose(en_dropped_reg));

endmodule : lbps_sequencer

// File: hw/lbps_pkg.sv
package lbps_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;       // Core clock period, 10 MHz

  // Delay figures in their own unit (microseconds), plain defaults
  localparam int RESET_HOLD_US  = 10000;    // Reset hold delay
  localparam int BOOST_START_US = 1000;     // Boost start delay
  localparam int GATE_REL_US    = 1000;     // Gate release delay

  // Least times round up to whole cycles
  localparam int RESET_HOLD_CYC  = (RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int BOOST_START_CYC = (BOOST_START_US * 1000 + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int GATE_REL_CYC    = (GATE_REL_US * 1000 + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

  // Width of the shared delay counters
  localparam int CNT_W = 20;

  // ------------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    LBPS_IO_RAMP   = 3'b000,  // Waiting for both io rails
    LBPS_CORE_RAMP = 3'b001,  // Core rail started, waiting power good
    LBPS_RST_HOLD  = 3'b010,  // Counting reset hold delay
    LBPS_RUN       = 3'b011   // System reset released
  } lbps_state_type;

endpackage : lbps_pkg

// File: sim/lbps_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host model: drives enable after a chosen lag
// ----------------------------------------------------------------
module lbps_host_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Bench commands
  input  wire logic       go,
  input  wire logic       drop,
  input  wire logic [3:0] lag,
  // Enable pin
  output logic            enable
);
  logic       enable_reg; // Enable level
  logic       pend_reg;   // Raise pending
  logic [3:0] wait_reg;   // Lag countdown
  assign enable = enable_reg;
  // Enable stays high until told to drop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      enable_reg <= 1'b0;
      pend_reg   <= 1'b0;
      wait_reg   <= 4'h0;
    end else if (drop) begin
      enable_reg <= 1'b0;
      pend_reg   <= 1'b0;
    end else if (go) begin
      pend_reg <= 1'b1;
      wait_reg <= lag;
    end else if (pend_reg && wait_reg == 4'h0) begin
      enable_reg <= 1'b1;
      pend_reg   <= 1'b0;
    end else if (pend_reg) begin
      wait_reg <= wait_reg - 4'h1;
    end
  end
endmodule : lbps_host_model

// File: sim/lbps_sequencer_tb.sv
`timescale 1ns/1ps
module lbps_sequencer_tb;
  import lbps_pkg::*;
  // ----------------------------------------------------------------
  // Signals; short delays keep the run brief
  // ----------------------------------------------------------------
  localparam int RH = 4;
  localparam int BS = 3;
  localparam int GR = 5;
  logic core_clk = 1'b0, rst = 1'b1, s_ok = 1'b0, s_det = 1'b1;
  logic g1 = 1'b0, g2 = 1'b0, gc = 1'b0, gs = 1'b0, gg = 1'b0;
  logic pmode = 1'b0, go = 1'b0, drop = 1'b0, enable;
  logic [3:0] lag = 4'h0;
  logic e1, e2, ec, b1, b2, rst_n, sgo, oe_n, dis_n;
  int n_errors = 0;
  int n_tests = 0;
  int n;
  lbps_sequencer #(.RESET_HOLD_CYCLES(RH), .BOOST_START_CYCLES(BS),
    .GATE_REL_CYCLES(GR)) DUT (.core_clk(core_clk), .rst(rst),
    .input_supply_ok(s_ok), .input_supply_det(s_det),
    .io_rail_one_good(g1), .io_rail_two_good(g2), .core_rail_good(gc),
    .source_driver_rail_good(gs), .gate_high_rail_good(gg),
    .enable(enable), .gate_in_panel_mode(pmode), .io_rail_one_en(e1),
    .io_rail_two_en(e2), .core_rail_en(ec), .boost_one_en(b1),
    .boost_two_en(b2), .system_reset_n(rst_n), .shaped_gate_out(sgo),
    .shaped_gate_oe_n(oe_n), .panel_discharge_n(dis_n));
  lbps_host_model host (.core_clk(core_clk), .rst(rst), .go(go),
    .drop(drop), .lag(lag), .enable(enable));
  always #50 core_clk = ~core_clk;
  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task check(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  function automatic logic pick(int k);
    case (k)
      0: pick = e1;
      1: pick = ec;
      2: pick = rst_n;
      3: pick = b1;
      4: pick = b2;
      5: pick = ~oe_n;
      6: pick = dis_n;
      default: pick = enable;
    endcase
  endfunction : pick
  // Edges until the watched output first reads high
  task wait_cnt(int k);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (pick(k) !== 1'b1 && n < 100);
  endtask : wait_cnt
  task pulse_go(logic [3:0] l);
    @(posedge core_clk);
    go  <= 1'b1;
    lag <= l;
    @(posedge core_clk);
    go  <= 1'b0;
  endtask : pulse_go
  task finish_test;
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_seq(logic mode, logic late);
    @(posedge core_clk) pmode <= mode;
    if (!late) pulse_go(4'h0);
    @(posedge core_clk) s_ok <= 1'b1;
    wait_cnt(0);
    check("io_en", {n[6:0], e2}, 8'h03);
    @(posedge core_clk) g1 <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 check("core_early", ec, 8'h00);
    @(posedge core_clk) g2 <= 1'b1;
    wait_cnt(1);
    check("core_en", 8'(n), 8'h01);
    @(posedge core_clk) gc <= 1'b1;
    wait_cnt(2);
    check("hold", 8'(n >= RH + 1 && n <= RH + 2), 8'h01);
    if (late) begin
      check("b1_early", b1, 8'h00);
      pulse_go(4'h6);
      wait_cnt(7);
    end
    wait_cnt(3);
    check("b1_start", 8'(n), 8'(BS));
    check("b2_early", b2, 8'h00);
    @(posedge core_clk) gs <= 1'b1;
    wait_cnt(4);
    check("b2_start", 8'(n), 8'h01);
    check("pre_rel", {oe_n, dis_n}, mode ? 8'h00 : 8'h03);
    @(posedge core_clk) gg <= 1'b1;
    wait_cnt(mode ? 6 : 5);
    check("rel", 8'(n), 8'(GR + mode));
    check("sgo_rel", {oe_n, sgo}, 8'h01);
    if (!mode) begin
      @(posedge core_clk) s_det <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 check("det_lo", dis_n, 8'h00);
      @(posedge core_clk) s_det <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 check("det_hi", dis_n, 8'h01);
    end
  endtask : t_seq
  task t_drop;
    @(posedge core_clk) drop <= 1'b1;
    @(posedge core_clk) drop <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 check("b1_drop", b1, 8'h00);
    pulse_go(4'h0);
    repeat (BS + 6) @(posedge core_clk);
    #1 check("b1_latch", {enable, b1}, 8'h02);
  endtask : t_drop
  task t_lockout;
    @(posedge core_clk) begin
      s_ok <= 1'b0;
      {g1, g2, gc, gs, gg} <= 5'h00;
    end
    @(posedge core_clk);
    #1 check("lockout", {e1, e2, ec, b1, b2, rst_n, dis_n, sgo},
      8'h00);
    @(posedge core_clk) drop <= 1'b1;
    @(posedge core_clk) drop <= 1'b0;
  endtask : t_lockout
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_seq(1'b0, 1'b0);
    t_drop;
    t_lockout;
    t_seq(1'b1, 1'b1);
    t_lockout;
    finish_test;
  end
  initial begin
    #200000;
    n_errors++;
    finish_test;
  end
endmodule : lbps_sequencer_tb
